// ==== bench/dec_model.sv ====
/*
 * Decoder-side model: presents one decoded operation per cycle to the datapath.
 * Assumes the bench calls issue just after a falling clock edge.
 */
`timescale 1ns/10ps
`default_nettype none

module dec_model (
    // Requests toward the datapath
    output var logic       o_exec,
    output var logic       o_step,
    output var logic [7:0] o_opcode,
    output var logic [7:0] o_operand
);
    // Start idle so nothing is taken before the bench asks
    initial begin
        o_exec = 1'b0;
        o_step = 1'b0;
        o_opcode = 8'h00;
        o_operand = 8'h00;
    end

    // Idle requests flip the operand so a stale byte is never reused by mistake
    task automatic issue(input logic en, input logic [7:0] op, input logic [7:0] opnd);
        o_exec = en;
        o_step = (op[7:6] == 2'h0);
        o_opcode = op;
        o_operand = en ? opnd : ~opnd;
    endtask : issue
endmodule : dec_model

`default_nettype wire

// ==== bench/tb.sv ====
/*
 * Self-checking bench for the 8-bit arithmetic/logic datapath.
 * Assumes alu8_core answers one clock after each taken request.
 */
`timescale 1ns/10ps
`default_nettype none

`define TB_CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end

module tb;
    logic       i_clk;
    logic       i_resetn;
    logic       exec;
    logic       step;
    logic [7:0] opcode;
    logic [7:0] operand;
    logic [7:0] acc;
    logic [7:0] flags;
    logic [7:0] step_res;
    logic       step_vld;
    logic       done;
    int         err_count = 0;
    int         num_checks = 0;
    int         cycles = 0;
    logic [7:0] exp_acc;
    // Rows: opcode, operand, result byte, flag byte; chained from the reset state
    logic [31:0] rows [15] = '{32'h807f7f00, 32'h80018094, 32'h80800045, 32'h880f1010,
        32'h9011ff93, 32'h980fef92, 32'hb8efef42, 32'ha00f0f14, 32'ha8010e00, 32'hb0808e84,
        32'h900f7f16, 32'h80810051, 32'h347f8095, 32'h35807f17, 32'h35010043};

    dec_model dec_u (.o_exec(exec), .o_step(step), .o_opcode(opcode), .o_operand(operand));

    alu8_core dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_exec(exec), .i_step(step),
        .i_opcode(opcode), .i_operand(operand), .o_acc(acc), .o_flags(flags),
        .o_step_res(step_res), .o_step_vld(step_vld), .o_done(done));

    // Free-running 100 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Hang guard, well above the few dozen cycles the tests need
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    // Steps off the accumulator field leave the accumulator alone; other ops replace it (compare rows carry old value)
    task automatic check_row(input logic [31:0] r);
        if (r[31:30] == 2'h0) begin
            `TB_CHK("step_res", r[15:8], step_res)
        end else begin
            exp_acc = r[15:8];
        end
        `TB_CHK("acc", exp_acc, acc)
        `TB_CHK("flags", r[7:0], flags)
        `TB_CHK("done", 1'b1, done)
        `TB_CHK("step_vld", (r[31:30] == 2'h0), step_vld)
    endtask : check_row

    initial begin
        i_resetn = 1'b0;
        exp_acc = 8'h00;
        repeat (3) @(negedge i_clk);
        `TB_CHK("acc", 8'h00, acc)
        `TB_CHK("flags", 8'h00, flags)
        `TB_CHK("step_res", 8'h00, step_res)
        `TB_CHK("step_vld", 1'b0, step_vld)
        `TB_CHK("done", 1'b0, done)
        i_resetn = 1'b1;
        // Back-to-back rows, first one at the first edge after release
        for (int i = 0; i < 15; i++) begin
            dec_u.issue(1'b1, rows[i][31:24], rows[i][23:16]);
            @(negedge i_clk);
            check_row(rows[i]);
        end
        $display("test rows done");
        dec_u.issue(1'b0, 8'h80, 8'h55);
        @(negedge i_clk);
        `TB_CHK("done", 1'b0, done)
        `TB_CHK("step_vld", 1'b0, step_vld)
        `TB_CHK("acc", exp_acc, acc)
        $display("test idle done");
        // A subtract leaves carry set, so a reset that failed to clear it would show below
        dec_u.issue(1'b1, 8'h90, 8'h42);
        @(negedge i_clk);
        dec_u.issue(1'b0, 8'h80, 8'h42);
        `TB_CHK("acc", 8'hbe, acc)
        `TB_CHK("flags", 8'h93, flags)
        i_resetn = 1'b0;
        #1;
        `TB_CHK("acc", 8'h00, acc)
        `TB_CHK("flags", 8'h00, flags)
        `TB_CHK("done", 1'b0, done)
        @(negedge i_clk);
        i_resetn = 1'b1;
        // Carry is clear again, so add_with_carry of zeros gives zero
        dec_u.issue(1'b1, 8'h88, 8'h00);
        @(negedge i_clk);
        `TB_CHK("acc", 8'h00, acc)
        `TB_CHK("flags", 8'h40, flags)
        $display("test reset done");
        // Steps on the accumulator field write back; decoder hands in the accumulator
        dec_u.issue(1'b1, 8'h3c, 8'h00);
        @(negedge i_clk);
        `TB_CHK("acc", 8'h01, acc)
        `TB_CHK("step_res", 8'h01, step_res)
        `TB_CHK("flags", 8'h00, flags)
        `TB_CHK("step_vld", 1'b1, step_vld)
        dec_u.issue(1'b1, 8'h3d, 8'h01);
        @(negedge i_clk);
        dec_u.issue(1'b0, 8'h80, 8'h00);
        `TB_CHK("acc", 8'h00, acc)
        `TB_CHK("step_res", 8'h00, step_res)
        `TB_CHK("flags", 8'h42, flags)
        $display("test step accumulator done");
        complete_run();
    end
endmodule : tb

`default_nettype wire

// ==== core/alu8_core.sv ====
/*
 * 8-bit arithmetic and logic datapath: accumulator, flag byte and the
 * plus_one / minus_one path for register or memory operands.
 * Assumes the instruction decoder presents a decoded opcode together with
 * the fetched operand and strobes i_exec for one cycle per operation;
 * operand fetch and write-back of stepped values, except to the accumulator, are done outside.
 */
// Overview of operation
// - Group 10, field 000 adds operand to accumulator; N cleared, C Z S H updated.
// - Field 001 add_with_carry, 010 subtract, 011 subtract_with_borrow, 111 compare.
// - subtract_with_borrow gives A-s-carry; subtracts set N, adds clear N.
// - Fields 100 AND, 110 OR, 101 XOR; C and N cleared; H set only for AND.
// - P/V holds parity for logic ops, overflow for arithmetic and step ops.
// - Overflow mode: P/V is 1 when the signed 8-bit result overflowed.
// - Parity mode: P/V is 1 when the result has even number of ones.
// - Step codes 100 plus_one, 101 minus_one keep carry, update Z S H V.
`timescale 1ns/10ps
`default_nettype none
`include "alu8_regs.svh"

module alu8_core (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    // Operation request from the decoder
    input  wire logic       i_exec,
    input  wire logic       i_step,
    input  wire logic [7:0] i_opcode,
    input  wire logic [7:0] i_operand,
    // Results
    output var  logic [7:0] o_acc,
    output var  logic [7:0] o_flags,
    output var  logic [7:0] o_step_res,
    output var  logic       o_step_vld,
    output var  logic       o_done
);

    alu8_pkg::alu8_state_s st_r;
    alu8_pkg::alu8_state_s st_nxt;

    // Even parity of a byte gives 1, as the flag wants
    function automatic logic even_par(input logic [7:0] v);
        even_par = ~(^v);
    endfunction : even_par

    // 9-bit add with carry in, half-carry and signed overflow
    logic [8:0] sum;
    logic [4:0] half;
    logic [7:0] opnd;
    logic       cin;
    logic       sub;
    logic [2:0] fld;
    logic       car;

    always_comb begin
        fld  = i_opcode[5:3];
        car  = st_r.flags[`ALU8_F_C];
        sub  = (fld == `ALU8_OP_SUB) || (fld == `ALU8_OP_SBB)
            || (fld == `ALU8_OP_CMP);
        cin  = ((fld == `ALU8_OP_ADC) || (fld == `ALU8_OP_SBB)) ? car : 1'b0;
        // Subtract as A + ~s + 1 - cin, borrow is the inverted carry out
        opnd = sub ? ~i_operand : i_operand;
        sum  = {1'b0, st_r.acc} + {1'b0, opnd} + {8'h00, (sub ? ~cin : cin)};
        half = {1'b0, st_r.acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, (sub ? ~cin : cin)};
    end

    // Plus_one / minus_one path on the operand, carry left alone
    logic [7:0] stp;
    logic       stp_dec;
    always_comb begin
        stp_dec = (i_opcode[2:0] == `ALU8_STEP_DEC);
        stp     = stp_dec ? i_operand - 8'h01 : i_operand + 8'h01;
    end

    // Next state: one operation per strobe, result visible next cycle
    always_comb begin
        logic [7:0] res;
        logic [7:0] f;
        res    = 8'h00;
        f      = st_r.flags;
        st_nxt = st_r;
        st_nxt.done     = 1'b0;
        st_nxt.step_vld = 1'b0;
        if (i_exec && i_step) begin
            f[`ALU8_F_Z]  = (stp == 8'h00);
            f[`ALU8_F_S]  = stp[7];
            f[`ALU8_F_N]  = stp_dec;
            f[`ALU8_F_H]  = stp_dec ? (i_operand[3:0] == 4'h0) : (i_operand[3:0] == 4'hf);
            f[`ALU8_F_PV] = stp_dec ? (i_operand == 8'h80) : (i_operand == 8'h7f);
            st_nxt.flags    = f;
            st_nxt.step_res = stp;
            st_nxt.step_vld = 1'b1;
            st_nxt.done     = 1'b1;
            // A step on the accumulator itself also lands there
            if (i_opcode[5:3] == `ALU8_STEP_ACC) begin
                st_nxt.acc = stp;
            end
        end else if (i_exec) begin
            case (fld)
                `ALU8_OP_AND: begin
                    res = st_r.acc & i_operand;
                    f[`ALU8_F_H] = 1'b1;
                end
                `ALU8_OP_OR: begin
                    res = st_r.acc | i_operand;
                    f[`ALU8_F_H] = 1'b0;
                end
                `ALU8_OP_XOR: begin
                    res = st_r.acc ^ i_operand;
                    f[`ALU8_F_H] = 1'b0;
                end
                default: begin
                    res = sum[7:0];
                    f[`ALU8_F_H] = sub ? ~half[4] : half[4];
                end
            endcase
            if (fld == `ALU8_OP_AND || fld == `ALU8_OP_OR || fld == `ALU8_OP_XOR) begin
                f[`ALU8_F_C]  = 1'b0;
                f[`ALU8_F_N]  = 1'b0;
                f[`ALU8_F_PV] = even_par(res);
            end else begin
                f[`ALU8_F_C]  = sub ? ~sum[8] : sum[8];
                f[`ALU8_F_N]  = sub;
                // Overflow: operands of like sign give a result of other sign
                f[`ALU8_F_PV] = (st_r.acc[7] == opnd[7]) && (res[7] != st_r.acc[7]);
            end
            f[`ALU8_F_Z] = (res == 8'h00);
            f[`ALU8_F_S] = res[7];
            st_nxt.flags = f;
            if (fld != `ALU8_OP_CMP) begin
                st_nxt.acc = res;
            end
            st_nxt.done = 1'b1;
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_r.acc      <= `ALU8_ACC_RST;
            st_r.flags    <= `ALU8_FLAGS_RST;
            st_r.step_res <= 8'h00;
            st_r.step_vld <= 1'b0;
            st_r.done     <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state flops
    always_comb begin
        o_acc      = st_r.acc;
        o_flags    = st_r.flags;
        o_step_res = st_r.step_res;
        o_step_vld = st_r.step_vld;
        o_done     = st_r.done;
    end

    // Assertion helpers
    logic [7:0] pa_acc;
    logic [7:0] pa_op;
    logic [7:0] pa_code;
    logic       pa_c;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pa_acc  <= 8'h00;
            pa_op   <= 8'h00;
            pa_code <= 8'h00;
            pa_c    <= 1'b0;
        end else begin
            pa_acc  <= st_r.acc;
            pa_op   <= i_operand;
            pa_code <= i_opcode;
            pa_c    <= st_r.flags[`ALU8_F_C];
        end
    end

    sequence s_arith(logic [2:0] code);
        i_exec && !i_step && i_opcode[5:3] == code;
    endsequence

    a_add_result: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_arith(`ALU8_OP_ADD) |=> (o_acc == pa_acc + pa_op) && !o_flags[`ALU8_F_N])
        else $error("add result or N wrong");
    a_adc_result: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_arith(`ALU8_OP_ADC) |=> o_acc == pa_acc + pa_op + {7'h00, pa_c})
        else $error("add_with_carry result wrong");
    a_sbb_result: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_arith(`ALU8_OP_SBB) |=> (o_acc == pa_acc - pa_op - {7'h00, pa_c}) && o_flags[`ALU8_F_N])
        else $error("subtract_with_borrow result wrong");
    a_and_flags: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_arith(`ALU8_OP_AND) |=> o_flags[`ALU8_F_H] && !o_flags[`ALU8_F_C] && !o_flags[`ALU8_F_N])
        else $error("AND flags wrong");
    a_logic_parity: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (s_arith(`ALU8_OP_OR) or s_arith(`ALU8_OP_XOR)) |=> o_flags[`ALU8_F_PV] == ~(^o_acc))
        else $error("parity flag wrong");
    a_sub_overflow: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_arith(`ALU8_OP_SUB) |=> o_flags[`ALU8_F_PV] ==
            ((pa_acc[7] != pa_op[7]) && (o_acc[7] != pa_acc[7])))
        else $error("overflow flag wrong");
    a_cmp_keeps: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_arith(`ALU8_OP_CMP) |=> (o_acc == $past(o_acc)) &&
            (o_flags[`ALU8_F_Z] == (pa_acc == pa_op)))
        else $error("compare changed accumulator");
    a_step_carry: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_exec && i_step |=> o_step_vld && o_flags[`ALU8_F_C] == pa_c &&
            o_step_res == (pa_code[0] ? pa_op - 8'h01 : pa_op + 8'h01))
        else $error("step changed carry or wrong value");
    a_pv_arith: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_arith(`ALU8_OP_ADD) |=> o_flags[`ALU8_F_PV] ==
            ((pa_acc[7] == pa_op[7]) && (o_acc[7] != pa_acc[7])))
        else $error("add overflow wrong");

    // Write-back of a step lands in the accumulator only for its own field
    a_step_acc: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_exec && i_step && (i_opcode[5:3] == `ALU8_STEP_ACC) |=> o_acc == o_step_res)
        else $error("step on accumulator not written back");
    a_step_other: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_exec && i_step && (i_opcode[5:3] != `ALU8_STEP_ACC) |=> o_acc == $past(o_acc))
        else $error("step on a register changed accumulator");
    a_or_xor_flags: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (s_arith(`ALU8_OP_OR) or s_arith(`ALU8_OP_XOR)) |=>
            !o_flags[`ALU8_F_H] && !o_flags[`ALU8_F_C] && !o_flags[`ALU8_F_N])
        else $error("OR or XOR flags wrong");

    // One answer pulse per taken strobe, none without one
    a_done_pulse: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_exec |=> o_done)
        else $error("operation not completed in one clock");
    a_done_idle: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !i_exec |=> !o_done && !o_step_vld)
        else $error("completion pulse without a request");

endmodule : alu8_core
`default_nettype wire

// ==== core/alu8_pkg.sv ====
/*
 * Types for the 8-bit arithmetic/logic unit.
 * Assumes alu8_regs.svh supplies the numeric constants.
 */
`default_nettype none

package alu8_pkg;

    // Registered state of the datapath
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] flags;
        logic [7:0] step_res;
        logic       step_vld;
        logic       done;
    } alu8_state_s;

endpackage : alu8_pkg

`default_nettype wire

// ==== core/alu8_regs.svh ====
/*
 * Opcode field values and timing figures for the 8-bit arithmetic/logic unit.
 * Assumes it is included by bare name; holds definitions only.
 */
`ifndef ALU8_REGS_SVH
`define ALU8_REGS_SVH

// Operation field, opcode bits 5-3
`define ALU8_OP_ADD      3'h0
`define ALU8_OP_ADC      3'h1
`define ALU8_OP_SUB      3'h2
`define ALU8_OP_SBB      3'h3
`define ALU8_OP_AND      3'h4
`define ALU8_OP_XOR      3'h5
`define ALU8_OP_OR       3'h6
`define ALU8_OP_CMP      3'h7
// Group field, opcode bits 7-6, register-operand arithmetic
`define ALU8_GRP_ARITH   2'h2
// Step field, opcode bits 2-0, for plus_one / minus_one
`define ALU8_STEP_INC    3'h4
`define ALU8_STEP_DEC    3'h5
// Step target field, opcode bits 5-3, naming the accumulator itself
`define ALU8_STEP_ACC    3'h7
// Flag byte bit positions
`define ALU8_F_C         0
`define ALU8_F_N         1
`define ALU8_F_PV        2
`define ALU8_F_H         4
`define ALU8_F_Z         6
`define ALU8_F_S         7
// Reset values
`define ALU8_ACC_RST     8'h00
`define ALU8_FLAGS_RST   8'h00
// Timing of the forms, in clock states
`define ALU8_T_REG       4
`define ALU8_T_IDX_STEP  23
`define ALU8_M_IDX_STEP  6

`endif
